//--- bench/rad_asserts.sv
module rad_asserts
  import rad_pkg::*;
(
  // watched ports
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire rad_chk_req_t chkReq,
  input wire rad_chk_rsp_t chkRsp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire setup = psel && !penable;
  AST_DONE: assert property (chkReq.valid |=> chkRsp.done)
    else $error("check not answered");
  AST_HOLD: assert property (!chkReq.valid |=> !chkRsp.done
    && $stable(chkRsp.permit) && $stable(chkRsp.region)) else $error("hold");
  AST_RST: assert property ($fell(rst) |-> chkRsp == '0
    && prdata == '0) else $error("reset state");
  AST_RO: assert property (setup && paddr == 12'h100
    |=> prdata == '0 && !pslverr) else $error("region 0 base");
  AST_UNMAP: assert property (setup && paddr == 12'h000
    |=> pslverr && prdata == '0) else $error("unmapped");
  AST_STAND: assert property (!setup |=> $stable(prdata)
    && $stable(pslverr)) else $error("read data moved");
  AST_ATTR0: assert property (setup && paddr == 12'h108
    |=> prdata[27:0] == '0) else $error("region 0 attr");
  AST_ATTRN: assert property (setup && paddr[3:0] == 4'h8
    |=> (prdata & 32'h0FFF0080) == '0) else $error("attr mask");
endmodule : rad_asserts

bind rad_region_decode rad_asserts u_chk(.*);

//--- bench/rad_master.sv
module rad_master
  import rad_pkg::*;
(
  // request side
  input wire logic core_clk,
  output rad_chk_req_t chkReq,
  input wire rad_chk_rsp_t chkRsp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial chkReq = '0;
  // one read check, lines scrambled once valid drops
  task automatic req(input logic [31:0] a, input logic s,
      output rad_chk_rsp_t r);
    @(posedge core_clk);
    chkReq <= '{1'b1, 1'b0, s, a};
    @(posedge core_clk);
    chkReq <= '{1'b0, 1'b1, ~s, ~a};
    // answer stands for this cycle only, take it mid-cycle
    @(negedge core_clk);
    r = chkRsp;
  endtask : req
endmodule : rad_master

//--- bench/region_attribute_decode_bench.sv
module region_attribute_decode_bench;
  import rad_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  rad_chk_req_t chkReq;
  rad_chk_rsp_t chkRsp;
  int miscompares = 0, num_checks = 0;
  rad_region_decode dut(.*);
  rad_master u_m(.*);
  initial forever #50 core_clk = ~core_clk;
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task cmp(input logic [32:0] s, input logic [32:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : cmp
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 9);
    if (pready !== 1'b1) begin
      miscompares++;
      complete_run;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk(input logic [31:0] a, input logic s, input logic [4:0] e);
    rad_chk_rsp_t r;
    u_m.req(a, s, r);
    cmp({r.done, r.permit, r.region}, {1'b1, e});
  endtask : chk
  task t_regs;
    apb(0, 12'h118, 32'h0);
    cmp(rd, 32'h0);
    apb(1, 12'h118, 32'hFFFFFFFF);
    apb(0, 12'h118, 32'h0);
    cmp(rd, 32'hF000FF7F);
    apb(1, 12'h108, 32'hFFFFFFFF);
    apb(0, 12'h108, 32'h0);
    cmp(rd, 32'hF0000000);
    apb(1, 12'h100, 32'hFFFF8000);
    apb(0, 12'h100, 32'h0);
    cmp({er, rd}, 33'h0);
    apb(0, 12'h000, 32'h0);
    cmp(er, 1'b1);
  endtask : t_regs
  task t_decode;
    apb(1, 12'h108, 32'h20000000);
    apb(1, 12'h110, 32'h00018000);
    apb(1, 12'h118, 32'h8000801F);
    chk(32'h00010000, 1, 5'h11);
    chk(32'h00010000, 0, 5'h01);
    chk(32'h0001E000, 1, 5'h10);
    chk(32'h00020000, 0, 5'h10);
    apb(1, 12'h004, 32'h1);
    chk(32'h0001E000, 1, 5'h00);
    apb(1, 12'h004, 32'h0);
    apb(1, 12'h118, 32'h8000801E);
    chk(32'h00010000, 1, 5'h10);
    apb(1, 12'h118, 32'h8000001B);
    chk(32'h00010000, 1, 5'h10);
    apb(1, 12'h118, 32'h8000007F);
    chk(32'h80000000, 1, 5'h11);
  endtask : t_decode
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_decode;
    complete_run;
  end
endmodule : region_attribute_decode_bench

//--- src/rad_consts.svh
`ifndef RAD_CONSTS_SVH
`define RAD_CONSTS_SVH

// register map, byte addresses
`define RAD_OFS_INVERT 12'h004
`define RAD_REGION_BLOCK 4'h1
`define RAD_KIND_LOW 2'h0
`define RAD_KIND_HIGH 2'h1
`define RAD_KIND_ATTR 2'h2

// attribute word layout
`define RAD_PERM_HI 31
`define RAD_PERM_LO 28
`define RAD_SUBDIS_HI 15
`define RAD_SUBDIS_LO 8
`define RAD_SIZE_HI 6
`define RAD_SIZE_LO 1
`define RAD_EN_BIT 0
`define RAD_ATTR_WMASK 32'hF000FF7F
`define RAD_ATTR0_WMASK 32'hF0000000

// permission field bits
`define RAD_PERM_S_RD 3
`define RAD_PERM_S_WR 2
`define RAD_PERM_NS_RD 1
`define RAD_PERM_NS_WR 0

// size codes and address width
`define RAD_SIZE_MIN 6'h0E
`define RAD_ADDR_MSB 31
`define RAD_SIZE_MAX 6'h1F
`define RAD_BASE_LSB 15

// reset values
`define RAD_ATTR_RESET 32'h00000000
`define RAD_INVERT_RESET 1'b0

`endif

//--- src/rad_pkg.sv
package rad_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic secure;
    logic [31:0] addr;
  } rad_chk_req_t;

  typedef struct packed {
    logic done;
    logic permit;
    logic [3:0] region;
  } rad_chk_rsp_t;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [3:0] idx;
    logic invert;
  } rad_sel_t;

  typedef struct packed {
    logic [15:0][31:0] attr;
    logic [15:0][16:0] baseLow;
    logic [15:0][31:0] baseHigh;
    logic invEn;
    logic [31:0] rdata;
    logic slvErr;
    rad_chk_rsp_t rsp;
  } rad_state_t;

endpackage : rad_pkg

//--- src/rad_region_decode.sv
`include "rad_consts.svh"

// How it works
// - permission field decides if transaction proceeds
// - bits 15..8 disable subregions 7..0
// - size code 14 is 32KB, doubling upward
// - attribute bit 0 enables the region
// - region 0 permissions only, covers everything
// - size code capped by address width
// - full attributes for regions 1 to 15
// - misaligned low base bits are ignored
// - region 0 base fixed zero, read-only
// - without inversion, secure keeps non-secure rights
module rad_region_decode
  import rad_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // transaction check
  input wire rad_chk_req_t chkReq,
  output rad_chk_rsp_t chkRsp
);

  rad_state_t state_reg;
  rad_state_t state_next;

  function automatic rad_sel_t regSel(input logic [11:0] a);
    rad_sel_t s;
    s = '0;
    if (a == `RAD_OFS_INVERT) begin
      s.valid = 1'b1;
      s.invert = 1'b1;
    end else if (a[11:8] == `RAD_REGION_BLOCK && a[3:2] != 2'h3
                 && a[1:0] == 2'h0) begin
      s.valid = 1'b1;
      s.kind = a[3:2];
      s.idx = a[7:4];
    end
    return s;
  endfunction : regSel

  function automatic logic [5:0] sizeEff(input logic [5:0] code);
    if (code > `RAD_SIZE_MAX) begin
      return `RAD_SIZE_MAX;
    end
    return code;
  endfunction : sizeEff

  function automatic logic regionHit(
    input logic [31:0] attr,
    input logic [16:0] low,
    input logic [31:0] high,
    input logic [31:0] addr
  );
    logic [5:0] code;
    logic [6:0] sh;
    logic [31:0] msk;
    logic [31:0] base;
    logic [7:0] dis;
    logic [2:0] sub;
    code = attr[`RAD_SIZE_HI:`RAD_SIZE_LO];
    sh = {1'b0, sizeEff(code)} + 7'h01;
    msk = 32'hFFFFFFFF << sh;
    base = {low, 15'h0000};
    dis = attr[`RAD_SUBDIS_HI:`RAD_SUBDIS_LO];
    sub = 3'(addr >> (sh - 7'h03));
    return attr[`RAD_EN_BIT]
      && code >= `RAD_SIZE_MIN
      && high == 32'h00000000
      && (addr & msk) == (base & msk)
      && !dis[sub];
  endfunction : regionHit

  function automatic logic allowed(
    input logic [3:0] sp,
    input logic wr,
    input logic sec,
    input logic inv
  );
    logic nsOk;
    logic sOk;
    nsOk = wr ? sp[`RAD_PERM_NS_WR] : sp[`RAD_PERM_NS_RD];
    sOk = wr ? sp[`RAD_PERM_S_WR] : sp[`RAD_PERM_S_RD];
    if (sec) begin
      return sOk || (!inv && nsOk);
    end
    return nsOk;
  endfunction : allowed

  always_comb begin
    rad_sel_t sel;
    logic [3:0] hitIdx;
    logic [3:0] sp;
    sel = regSel(paddr);
    hitIdx = 4'h0;
    sp = 4'h0;
    state_next = state_reg;
    state_next.rsp.done = 1'b0;
    // transaction check, highest region wins, region 0 catches all
    if (chkReq.valid) begin
      for (int i = 1; i < 16; i++) begin
        if (regionHit(state_reg.attr[i], state_reg.baseLow[i],
                      state_reg.baseHigh[i], chkReq.addr)) begin
          hitIdx = 4'(i);
        end
      end
      sp = state_reg.attr[hitIdx][`RAD_PERM_HI:`RAD_PERM_LO];
      state_next.rsp.done = 1'b1;
      state_next.rsp.region = hitIdx;
      state_next.rsp.permit = allowed(sp, chkReq.write, chkReq.secure,
                                      state_reg.invEn);
    end
    // apb read data captured in setup phase
    if (psel && !penable) begin
      state_next.slvErr = !sel.valid;
      state_next.rdata = 32'h00000000;
      if (sel.invert) begin
        state_next.rdata = {31'h00000000, state_reg.invEn};
      end else if (sel.valid && sel.idx != 4'h0) begin
        unique case (sel.kind)
          `RAD_KIND_LOW:
            state_next.rdata = {state_reg.baseLow[sel.idx], 15'h0000};
          `RAD_KIND_HIGH:
            state_next.rdata = state_reg.baseHigh[sel.idx];
          default:
            state_next.rdata = state_reg.attr[sel.idx];
        endcase
      end else if (sel.valid && sel.kind == `RAD_KIND_ATTR) begin
        state_next.rdata = state_reg.attr[0];
      end
    end
    // apb write at access phase
    if (psel && penable && pwrite && sel.valid) begin
      if (sel.invert) begin
        state_next.invEn = pwdata[0];
      end else if (sel.idx == 4'h0) begin
        if (sel.kind == `RAD_KIND_ATTR) begin
          state_next.attr[0] = pwdata & `RAD_ATTR0_WMASK;
        end
      end else begin
        unique case (sel.kind)
          `RAD_KIND_LOW:
            state_next.baseLow[sel.idx] = pwdata[31:`RAD_BASE_LSB];
          `RAD_KIND_HIGH:
            state_next.baseHigh[sel.idx] = pwdata;
          default:
            state_next.attr[sel.idx] = pwdata & `RAD_ATTR_WMASK;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.invEn <= `RAD_INVERT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.slvErr;
  assign chkRsp = state_reg.rsp;

endmodule : rad_region_decode
